// >>> verilog/ctf_map.vh
// Register map, reset values and timing figures of the test frame timer.
// Included by the timing generator; definitions only.
`ifndef CTF_MAP_VH
`define CTF_MAP_VH
// Register indices; byte address is four times the index
`define CTF_IDX_CTRL      6'h01
`define CTF_IDX_LSIZE_HI  6'h04
`define CTF_IDX_LSIZE_LO  6'h05
`define CTF_IDX_BAR_HI    6'h06
`define CTF_IDX_BAR_LO    6'h07
`define CTF_IDX_ACT_HI    6'h08
`define CTF_IDX_ACT_LO    6'h09
`define CTF_IDX_TOT_HI    6'h0A
`define CTF_IDX_TOT_LO    6'h0B
`define CTF_IDX_LPD_HI    6'h0C
`define CTF_IDX_LPD_LO    6'h0D
`define CTF_IDX_BPORCH    6'h0E
`define CTF_IDX_FPORCH    6'h0F
`define CTF_IDX_COLOR0    6'h10
`define CTF_IDX_COLOR1    6'h11
`define CTF_IDX_COLOR2    6'h12
`define CTF_IDX_STATUS    6'h1C
// Reset values
`define CTF_RST_CTRL      8'h30
`define CTF_RST_LSIZE_HI  8'h07
`define CTF_RST_LSIZE_LO  8'h80
`define CTF_RST_BAR_HI    8'h00
`define CTF_RST_BAR_LO    8'hF0
`define CTF_RST_ACT_HI    8'h01
`define CTF_RST_ACT_LO    8'hE0
`define CTF_RST_TOT_HI    8'h02
`define CTF_RST_TOT_LO    8'h0D
`define CTF_RST_LPD_HI    8'h0C
`define CTF_RST_LPD_LO    8'h67
`define CTF_RST_BPORCH    8'h21
`define CTF_RST_FPORCH    8'h0A
`define CTF_RST_COLOR0    8'hAA
`define CTF_RST_COLOR1    8'h33
`define CTF_RST_COLOR2    8'hF0
// Control register fields
`define CTF_CTRL_EN       7
`define CTF_CTRL_FIXED    6
`define CTF_CTRL_RATE_HI  5
`define CTF_CTRL_RATE_LO  4
`define CTF_CTRL_BLK_HI   3
`define CTF_CTRL_BLK_LO   0
// Lane rate codes
`define CTF_RATE_400M     2'h0
`define CTF_RATE_800M     2'h1
`define CTF_RATE_1200M    2'h2
`define CTF_RATE_1600M    2'h3
// Timing: clock period and line period units, in picoseconds
`define CTF_CLK_PS        40000
`define CTF_UNIT_10NS_PS  10000
`define CTF_UNIT_13NS_PS  13333
`define CTF_UNIT_20NS_PS  20000
`endif

// >>> verilog/ctf_timing.v
// Test pattern frame timer: line period, vertical porches and color bytes,
// with an APB register slave. Assumes ref_clk at 25 MHz and an APB master
// on the same clock; the byte stream feeds a packet former downstream.
`timescale 1ns/10ps
`include "ctf_map.vh"

module ctf_timing (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Video stream
  output reg         frame_start,
  output reg         frame_end,
  output reg         line_start,
  output reg         line_active,
  output reg         pix_valid,
  output reg  [7:0]  pix_data
);

  // Line period units per clock, 40 ns over the unit
  localparam integer STEP_10NS = `CTF_CLK_PS / `CTF_UNIT_10NS_PS;
  localparam integer STEP_13NS = `CTF_CLK_PS / `CTF_UNIT_13NS_PS;
  localparam integer STEP_20NS = `CTF_CLK_PS / `CTF_UNIT_20NS_PS;

  reg        rst_meta;
  reg        rst_sync;
  reg [7:0]  ctrl;
  reg [7:0]  lsize_hi;
  reg [7:0]  lsize_lo;
  reg [7:0]  bar_hi;
  reg [7:0]  bar_lo;
  reg [7:0]  act_hi;
  reg [7:0]  act_lo;
  reg [7:0]  tot_hi;
  reg [7:0]  tot_lo;
  reg [7:0]  lpd_hi;
  reg [7:0]  lpd_lo;
  reg [7:0]  bporch;
  reg [7:0]  fporch;
  reg [7:0]  color0;
  reg [7:0]  color1;
  reg [7:0]  color2;
  reg [16:0] unit_cnt;
  reg [15:0] line_idx;
  reg [15:0] byte_cnt;
  reg [15:0] seg_cnt;
  reg [1:0]  bar_idx;
  reg [3:0]  blk_cnt;
  reg [1:0]  col_idx;
  reg        running;
  reg [3:0]  step;
  reg [7:0]  rd_val;

  wire [5:0]  idx        = paddr[7:2];
  wire        setup      = psel & ~penable;
  wire        mapped;
  wire        wr_en      = psel & penable & pwrite & ~pslverr;
  wire        enable     = ctrl[`CTF_CTRL_EN];
  wire        fixed_mode = ctrl[`CTF_CTRL_FIXED];
  wire [3:0]  blk_size   = ctrl[`CTF_CTRL_BLK_HI:`CTF_CTRL_BLK_LO];
  wire [15:0] total      = {tot_hi, tot_lo};
  wire [15:0] period     = {lpd_hi, lpd_lo};
  wire [15:0] act_lines  = {act_hi, act_lo};
  wire [15:0] line_bytes = {lsize_hi, lsize_lo};
  wire [15:0] bar_len    = {bar_hi, bar_lo};
  wire [16:0] act_first  = {9'h000, bporch};
  wire [16:0] act_end    = act_first + {1'b0, act_lines};
  wire [16:0] fe_line    = act_end + {9'h000, fporch};
  wire [16:0] next_unit  = unit_cnt + {13'h0000, step};
  wire        line_tick  = running & (next_unit >= {1'b0, period});
  wire        last_line  = ({1'b0, line_idx} + 17'h00001) >= {1'b0, total};
  wire [15:0] next_line  = last_line ? 16'h0000 : line_idx + 16'h0001;
  wire        next_act   = ({1'b0, next_line} >= act_first) & ({1'b0, next_line} < act_end);
  wire        fixed_ok   = blk_size != 4'h0;

  // Picks one of the three colour bytes
  function [7:0] pick_color;
    input [1:0] sel;
    input [7:0] c0;
    input [7:0] c1;
    input [7:0] c2;
    begin
      case (sel)
        2'd0:    pick_color = c0;
        2'd1:    pick_color = c1;
        default: pick_color = c2;
      endcase
    end
  endfunction

  // Reset release through two flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Units added per clock for the lane rate
  always @* begin
    case (ctrl[`CTF_CTRL_RATE_HI:`CTF_CTRL_RATE_LO])
      `CTF_RATE_400M:  step = STEP_20NS[3:0];
      `CTF_RATE_1200M: step = STEP_13NS[3:0];
      default:         step = STEP_10NS[3:0];
    endcase
  end

  // Address decode and read mux
  assign mapped = (paddr[1:0] == 2'b00) &
                  ((idx == `CTF_IDX_CTRL) | (idx == `CTF_IDX_STATUS) |
                   ((idx >= `CTF_IDX_LSIZE_HI) & (idx <= `CTF_IDX_COLOR2)));
  always @* begin
    case (idx)
      `CTF_IDX_CTRL:     rd_val = ctrl;
      `CTF_IDX_LSIZE_HI: rd_val = lsize_hi;
      `CTF_IDX_LSIZE_LO: rd_val = lsize_lo;
      `CTF_IDX_BAR_HI:   rd_val = bar_hi;
      `CTF_IDX_BAR_LO:   rd_val = bar_lo;
      `CTF_IDX_ACT_HI:   rd_val = act_hi;
      `CTF_IDX_ACT_LO:   rd_val = act_lo;
      `CTF_IDX_TOT_HI:   rd_val = tot_hi;
      `CTF_IDX_TOT_LO:   rd_val = tot_lo;
      `CTF_IDX_LPD_HI:   rd_val = lpd_hi;
      `CTF_IDX_LPD_LO:   rd_val = lpd_lo;
      `CTF_IDX_BPORCH:   rd_val = bporch;
      `CTF_IDX_FPORCH:   rd_val = fporch;
      `CTF_IDX_COLOR0:   rd_val = color0;
      `CTF_IDX_COLOR1:   rd_val = color1;
      `CTF_IDX_COLOR2:   rd_val = color2;
      `CTF_IDX_STATUS:   rd_val = {running, line_active, pix_valid, 5'h00};
      default:           rd_val = 8'h00;
    endcase
  end

  // Zero wait: answer in every access phase
  assign pready = 1'b1;

  // Read data and error captured in the setup phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (!rst_sync) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= mapped ? {24'h000000, rd_val} : 32'h00000000;
      pslverr <= ~mapped;
    end
  end

  // Register writes in the access phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= `CTF_RST_CTRL;
      lsize_hi <= `CTF_RST_LSIZE_HI;
      lsize_lo <= `CTF_RST_LSIZE_LO;
      bar_hi   <= `CTF_RST_BAR_HI;
      bar_lo   <= `CTF_RST_BAR_LO;
      act_hi   <= `CTF_RST_ACT_HI;
      act_lo   <= `CTF_RST_ACT_LO;
      tot_hi   <= `CTF_RST_TOT_HI;
      tot_lo   <= `CTF_RST_TOT_LO;
      lpd_hi   <= `CTF_RST_LPD_HI;
      lpd_lo   <= `CTF_RST_LPD_LO;
      bporch   <= `CTF_RST_BPORCH;
      fporch   <= `CTF_RST_FPORCH;
      color0   <= `CTF_RST_COLOR0;
      color1   <= `CTF_RST_COLOR1;
      color2   <= `CTF_RST_COLOR2;
    end else if (wr_en) begin
      case (idx)
        `CTF_IDX_CTRL:     ctrl     <= pwdata[7:0];
        `CTF_IDX_LSIZE_HI: lsize_hi <= pwdata[7:0];
        `CTF_IDX_LSIZE_LO: lsize_lo <= pwdata[7:0];
        `CTF_IDX_BAR_HI:   bar_hi   <= pwdata[7:0];
        `CTF_IDX_BAR_LO:   bar_lo   <= pwdata[7:0];
        `CTF_IDX_ACT_HI:   act_hi   <= pwdata[7:0];
        `CTF_IDX_ACT_LO:   act_lo   <= pwdata[7:0];
        `CTF_IDX_TOT_HI:   tot_hi   <= pwdata[7:0];
        `CTF_IDX_TOT_LO:   tot_lo   <= pwdata[7:0];
        `CTF_IDX_LPD_HI:   lpd_hi   <= pwdata[7:0];
        `CTF_IDX_LPD_LO:   lpd_lo   <= pwdata[7:0];
        `CTF_IDX_BPORCH:   bporch   <= pwdata[7:0];
        `CTF_IDX_FPORCH:   fporch   <= pwdata[7:0];
        `CTF_IDX_COLOR0:   color0   <= pwdata[7:0];
        `CTF_IDX_COLOR1:   color1   <= pwdata[7:0];
        `CTF_IDX_COLOR2:   color2   <= pwdata[7:0];
        default:           ctrl     <= ctrl;
      endcase
    end
  end

  // Line timing and frame sequencing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      running     <= 1'b0;
      unit_cnt    <= 17'h00000;
      line_idx    <= 16'h0000;
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
      line_start  <= 1'b0;
      line_active <= 1'b0;
    end else if (!rst_sync || !enable) begin
      running     <= 1'b0;
      unit_cnt    <= 17'h00000;
      line_idx    <= 16'h0000;
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
      line_start  <= 1'b0;
      line_active <= 1'b0;
    end else if (!running) begin
      // First line of the first frame
      running     <= 1'b1;
      unit_cnt    <= 17'h00000;
      line_idx    <= 16'h0000;
      frame_start <= 1'b1;
      frame_end   <= 1'b0;
      line_start  <= 1'b1;
      line_active <= bporch == 8'h00 && act_lines != 16'h0000;
    end else if (line_tick) begin
      unit_cnt    <= 17'h00000;
      line_idx    <= next_line;
      frame_start <= last_line;
      // End of frame after the front porch, or at wrap if it does not fit
      frame_end   <= ({1'b0, next_line} == fe_line) | (last_line & (fe_line >= {1'b0, total}));
      line_start  <= 1'b1;
      line_active <= next_act;
    end else begin
      unit_cnt    <= next_unit;
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
      line_start  <= 1'b0;
    end
  end

  // Byte stream of an active line
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_valid <= 1'b0;
      pix_data  <= 8'h00;
      byte_cnt  <= 16'h0000;
      seg_cnt   <= 16'h0000;
      bar_idx   <= 2'd0;
      blk_cnt   <= 4'h0;
      col_idx   <= 2'd0;
    end else if (!rst_sync || line_start) begin
      pix_valid <= 1'b0;
      pix_data  <= 8'h00;
      byte_cnt  <= 16'h0000;
      seg_cnt   <= 16'h0000;
      bar_idx   <= 2'd0;
      blk_cnt   <= 4'h0;
      col_idx   <= 2'd0;
    // Stop at a line boundary or disable so no byte trails into a blank line
    end else if (line_active && running && enable && !line_tick && byte_cnt < line_bytes) begin
      pix_valid <= 1'b1;
      byte_cnt  <= byte_cnt + 16'h0001;
      if (fixed_mode) begin
        // Field of blk_size bytes cycling the colour bytes
        pix_data <= pick_color(col_idx, color0, color1, color2);
        if (!fixed_ok || blk_cnt + 4'h1 >= blk_size) begin
          blk_cnt <= 4'h0;
          col_idx <= 2'd0;
        end else begin
          blk_cnt <= blk_cnt + 4'h1;
          col_idx <= (col_idx == 2'd2) ? 2'd0 : col_idx + 2'd1;
        end
      end else begin
        // Bars 0 and 1 last bar_len bytes, bar 2 takes the rest
        pix_data <= pick_color(bar_idx, color0, color1, color2);
        if (bar_idx != 2'd2 && seg_cnt + 16'h0001 >= bar_len) begin
          seg_cnt <= 16'h0000;
          bar_idx <= bar_idx + 2'd1;
        end else begin
          seg_cnt <= seg_cnt + 16'h0001;
        end
      end
    end else begin
      pix_valid <= 1'b0;
    end
  end

endmodule

// >>> tb/ctf_timing_props.sv
// Checker of the test frame timer: stream framing and APB answers.
// Bound to ctf_timing from the testbench top file; one clock domain.
`timescale 1ns/10ps
`include "ctf_map.vh"
module ctf_timing_props (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst_n,
  // APB slave
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Video stream
  input wire        frame_start,
  input wire        frame_end,
  input wire        line_start,
  input wire        line_active,
  input wire        pix_valid,
  input wire [7:0]  pix_data
);
  logic       fix_sh;
  logic [7:0] col0_sh;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of fixed mode and first pattern byte
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fix_sh  <= 1'b0;
      col0_sh <= `CTF_RST_COLOR0;
    end else if (psel && penable && pwrite && !pslverr) begin
      if (paddr == {`CTF_IDX_CTRL, 2'b00}) fix_sh <= pwdata[`CTF_CTRL_FIXED];
      if (paddr == {`CTF_IDX_COLOR0, 2'b00}) col0_sh <= pwdata[7:0];
    end
  end
  chk_frame_line: assert property (frame_start |-> line_start)
    else $error("frame start without line start");
  chk_end_on_line: assert property (frame_end |-> line_start)
    else $error("frame end off a line start");
  chk_pix_active: assert property (pix_valid |-> line_active)
    else $error("byte outside an active line");
  chk_pix_follow: assert property ($rose(pix_valid) |-> $past(line_start, 2))
    else $error("bytes not right after line start");
  chk_active_rise: assert property ($rose(line_active) |-> line_start)
    else $error("active line began mid line");
  chk_fixed_first: assert property ($rose(pix_valid) && fix_sh |-> pix_data == col0_sh)
    else $error("fixed line not opened by first byte");
  chk_err_zero: assert property (psel && penable && pslverr |-> prdata == 32'h0)
    else $error("error answer with data");
  chk_rd_width: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_err_align: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access accepted");
  cover property (frame_end);
  cover property ($rose(pix_valid) && fix_sh);
  cover property (psel && penable && pslverr);
endmodule

// >>> tb/ctf_sink.sv
// Downstream receiver model: line spacing, frame layout, active bytes.
// Watches the stream on the shared clock and never stalls it.
`timescale 1ns/10ps
module ctf_sink (
  // Clock
  input wire       ref_clk,
  // Video stream
  input wire       frame_start,
  input wire       frame_end,
  input wire       line_start,
  input wire       line_active,
  input wire       pix_valid,
  input wire [7:0] pix_data
);
  int         cyc, period, ln, nl, flen, act, n_act, first_act, fe_line, nb, lbytes, nfr;
  logic [7:0] line_buf [0:15];
  // Count cycles, lines and bytes; latch frame figures at frame start and the end line at frame end
  always @(posedge ref_clk) begin
    nl = frame_start ? 0 : ln + 1;
    cyc <= cyc + 1;
    if (pix_valid) begin
      line_buf[nb[3:0]] <= pix_data;
      nb <= nb + 1;
    end
    if (line_start) begin
      period <= cyc;
      cyc <= 1;
      nb <= 0;
      ln <= nl;
      if (nb != 0) lbytes <= nb;
      if (line_active) act <= act + 1;
      if (line_active && act == 0) first_act <= nl;
    end
    if (frame_start) begin
      flen <= ln + 1;
      n_act <= act;
      act <= 0;
      nfr <= nfr + 1;
    end
    if (frame_end) fe_line <= nl;
  end
endmodule

// >>> tb/ctf_timing_tb.sv
// Testbench of the test frame timer: APB registers and stream layout.
// Assumes ctf_map.vh on the include path and the receiver model.
`timescale 1ns/10ps
`include "ctf_map.vh"
module ctf_timing_tb;
  logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  wire         pready, pslverr, frame_start, frame_end, line_start, line_active, pix_valid;
  wire [31:0]  prdata;
  wire [7:0]   pix_data;
  int          error_cnt = 0, cmp_count = 0;
  int          st [0:3] = '{2, 4, 3, 4};
  int          bk [0:2] = '{1, 5, 15};
  logic [7:0]  col [0:2] = '{8'h11, 8'h22, 8'h33};
  logic [7:0]  cv [0:11] = '{8'h00, 8'h0C, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00, 8'h08, 8'h00, 8'h64, 8'h02, 8'h01};
  logic [7:0]  rv [0:10] = '{`CTF_RST_ACT_HI, `CTF_RST_ACT_LO, `CTF_RST_TOT_HI, `CTF_RST_TOT_LO,
                             `CTF_RST_LPD_HI, `CTF_RST_LPD_LO, `CTF_RST_BPORCH, `CTF_RST_FPORCH,
                             `CTF_RST_COLOR0, `CTF_RST_COLOR1, `CTF_RST_COLOR2};
  ctf_timing i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
                    .pslverr, .frame_start, .frame_end, .line_start, .line_active, .pix_valid, .pix_data);
  ctf_sink i_sink (.ref_clk, .frame_start, .frame_end, .line_start, .line_active, .pix_valid, .pix_data);
  // Free running clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // One APB transfer, held until pready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 16) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] v);
    apb(1'b1, {ix, 2'b00}, {24'hC3C3C3, v});
  endtask
  task automatic rchk(input logic [5:0] ix, input logic [7:0] v);
    apb(1'b0, {ix, 2'b00}, 32'h0);
    chk(q, {24'h0, v});
    chk(32'(e), 32'h0);
  endtask
  task automatic wait_frm();
    int t;
    t = i_sink.nfr + 2;
    for (int n = 0; n < 3000 && i_sink.nfr < t; n++) @(posedge ref_clk);
    if (i_sink.nfr < t) begin
      error_cnt++;
      summarize();
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) rchk(6'(i + 8), rv[i]);
    for (int i = 0; i < 11; i++) wr(6'(i + 8), 8'(8'h5A ^ i));
    for (int i = 0; i < 11; i++) rchk(6'(i + 8), 8'(8'h5A ^ i));
    apb(1'b0, 8'hFC, 32'h0);
    chk({q[31:1], e}, 32'h1);
    apb(1'b1, 8'h2D, 32'h0);
    chk(32'(e), 32'h1);
    rchk(`CTF_IDX_TOT_LO, 8'h59);
    for (int i = 0; i < 12; i++) wr(6'(i + 4), cv[i]);
    for (int i = 0; i < 3; i++) wr(6'(i + 16), col[i]);
    wr(`CTF_IDX_CTRL, 8'h90);
    wait_frm();
    chk(i_sink.period, 32'd25);
    chk(i_sink.flen, 32'd8);
    chk(i_sink.first_act, 32'd2);
    chk(i_sink.n_act, 32'd2);
    chk(i_sink.fe_line, 32'd5);
    chk(i_sink.lbytes, 32'd12);
    for (int i = 0; i < 12; i++) chk(32'(i_sink.line_buf[i]), 32'(col[i / 4]));
    for (int b = 0; b < 3; b++) begin
      wr(`CTF_IDX_CTRL, 8'hD0 | 8'(bk[b]));
      wait_frm();
      for (int i = 0; i < 12; i++) chk(32'(i_sink.line_buf[i]), 32'(col[(i % bk[b]) % 3]));
    end
    for (int r = 0; r < 4; r++) begin
      wr(`CTF_IDX_CTRL, 8'h80 | 8'(r << 4));
      wait_frm();
      chk(i_sink.period, 32'((100 + st[r] - 1) / st[r]));
      rchk(`CTF_IDX_STATUS, 8'h80);
    end
    summarize();
  end
endmodule
bind ctf_timing ctf_timing_props i_props (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .frame_start, .frame_end, .line_start, .line_active, .pix_valid, .pix_data);
